// >>> design/acs_pkg.sv
// Shared constants and types of the conversion sequencer
`default_nettype none
package acs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SEL  = 8'h04;
  localparam logic [7:0] OFF_RES  = 8'h08;
  localparam logic [7:0] OFF_TRIG = 8'h0c;
  // Control and status fields
  localparam int CS_EN    = 7;
  localparam int CS_START = 6;
  localparam int CS_AUTO  = 5;
  localparam int CS_FLAG  = 4;
  localparam int CS_IE    = 3;
  localparam int CS_PS    = 0;
  localparam int PS_W     = 3;
  // Selection and trigger fields
  localparam int SEL_REF  = 6;
  localparam int SEL_CHAN = 0;
  localparam int TRIG_FREE = 0;
  // Reference encodings
  localparam logic [1:0] REF_EXT     = 2'h0;
  localparam logic [1:0] REF_SUPPLY  = 2'h1;
  localparam logic [1:0] REF_RSVD    = 2'h2;
  localparam logic [1:0] REF_BANDGAP = 2'h3;
  // Sleep modes that start a conversion
  localparam logic [2:0] SLEEP_IDLE = 3'h0;
  localparam logic [2:0] SLEEP_NR   = 3'h1;
  // Result
  localparam int         RES_W      = 10;
  localparam logic [9:0] FULL_SCALE = 10'h3ff;
  localparam logic [9:0] SAR_MSB    = 10'h200;
  localparam logic [3:0] SAR_TOP    = 4'h9;
  // Timing in tenths of a converter clock cycle
  localparam int NORM_SAMP_X10  = 15;
  localparam int NORM_TOTAL_X10 = 130;
  localparam int AUTO_SAMP_X10  = 20;
  localparam int AUTO_TOTAL_X10 = 135;
  localparam int FIRST_SAMP_X10 = 135;
  localparam int FIRST_TOTAL_X10 = 250;
  // Same instants in converter clock half-cycles
  localparam logic [7:0] NORM_SAMP   = 8'(NORM_SAMP_X10 * 2 / 10);
  localparam logic [7:0] NORM_TOTAL  = 8'(NORM_TOTAL_X10 * 2 / 10);
  localparam logic [7:0] AUTO_SAMP   = 8'(AUTO_SAMP_X10 * 2 / 10);
  localparam logic [7:0] AUTO_TOTAL  = 8'(AUTO_TOTAL_X10 * 2 / 10);
  localparam logic [7:0] FIRST_SAMP  = 8'(FIRST_SAMP_X10 * 2 / 10);
  localparam logic [7:0] FIRST_TOTAL = 8'(FIRST_TOTAL_X10 * 2 / 10);
  localparam int PRE_W = 7;

  typedef enum logic [1:0] {KIND_NORMAL, KIND_FIRST, KIND_AUTO} acs_kind_t;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic [3:0] chan;
  } acs_sel_t;
endpackage
`default_nettype wire

// >>> design/acs_sequencer.sv
// Conversion sequencer with AHB-Lite register slave
// Summary of operation
// - Normal conversion samples at 1.5 cycles, ends at 13.
// - Auto-triggered conversion samples at 2 cycles, ends at 13.5.
// - First conversion after enable lasts 25 cycles, sampling at 13.5.
// - Active selection tracks the shadow until start, then freezes.
// - Tracking resumes in the final converter cycle.
// - A written start begins on the next converter clock rising edge.
// - A safely written selection applies to the next conversion.
// - In free running, a change hits the conversion after the current one.
// - Reference is analog supply, internal bandgap, or external pin.
// - Reference codes: 00 external, 01 supply, 11 bandgap, 10 reserved.
// - Inputs above the reference saturate near full scale.
// - Halting into idle or noise-reduction sleep starts a conversion.
// - A wake-up does not stop a sleep conversion or its interrupt.
// - Other sleep modes never clear the enable by themselves.
// - Output code is linear from zero to all ones.
// - Start bit reads one while converting, cleared at the end.
// - At the end the result is stored and the done flag set.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input  wire  logic                hclk,
  input  wire  logic                hresetn,
  // AHB-Lite slave
  input  wire  logic                hsel,
  input  wire  logic [31:0]         haddr,
  input  wire  logic [1:0]          htrans,
  input  wire  logic                hwrite,
  input  wire  logic [2:0]          hsize,
  input  wire  logic [31:0]         hwdata,
  input  wire  logic                hready,
  output logic       [31:0]         hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Analog side
  input  wire  logic                cmp_above,
  input  wire  logic                trigger_in,
  output acs_sel_t                  active_sel,
  output logic                      ref_ext,
  output logic                      ref_supply,
  output logic                      ref_bandgap,
  output logic                      sample_hold,
  output logic       [RES_W-1:0]    dac_code,
  output logic                      converter_on,
  // Sleep controller and interrupt
  input  wire  logic                cpu_halted,
  input  wire  logic [2:0]          sleep_mode,
  output logic                      conv_irq
);
  logic              en_r, auto_r, ie_r, free_r, flag_r, start_req_r;
  logic [PS_W-1:0]   ps_r;
  acs_sel_t          shadow_r, active_r;
  logic [PRE_W-1:0]  pre_cnt_r, half_len;
  logic              phase_r, trig_d_r, halted_d_r;
  logic              busy_r, first_pend_r, resolving_r;
  acs_kind_t         kind_r;
  logic [7:0]        half_cnt_r, samp_half, total_half;
  logic [RES_W-1:0]  sar_r, result_r, dac_r, sar_nxt;
  logic [3:0]        bit_r;
  logic              wr_pend_r, rd_pend_r, hready_r;
  logic [7:0]        addr_r;
  logic [31:0]       rdata_r;
  logic              ref_ext_r, ref_sup_r, ref_bg_r, samp_r, irq_r;
  // Bus phase decode
  logic ap, wr_ctrl;
  assign ap      = hsel && hready && htrans[1];
  assign wr_ctrl = wr_pend_r && (addr_r == OFF_CTRL);
  // Converter clock as half-cycle ticks
  logic half_tick, rise_tick, trig_start, sleep_start, begin_norm, restart, start_any;
  logic done, sample, final_cyc, sar_step;
  assign half_len   = PRE_W'(1) << ((ps_r == '0) ? 3'h0 : ps_r - 3'h1);
  assign half_tick  = en_r && (pre_cnt_r == half_len - PRE_W'(1));
  assign rise_tick  = half_tick && !phase_r;
  assign trig_start = en_r && auto_r && !free_r && trigger_in && !trig_d_r && !busy_r;
  assign sleep_start = en_r && !busy_r && !start_req_r && cpu_halted && !halted_d_r &&
                       (sleep_mode == SLEEP_IDLE || sleep_mode == SLEEP_NR);
  assign begin_norm = rise_tick && start_req_r && !busy_r;
  assign done       = busy_r && half_tick && (half_cnt_r + 8'h1 == total_half);
  assign sample     = busy_r && half_tick && (half_cnt_r + 8'h1 == samp_half);
  assign restart    = done && auto_r && free_r;
  assign start_any  = begin_norm || trig_start || restart;
  assign final_cyc  = busy_r && (half_cnt_r + 8'h2 >= total_half);
  assign sar_step   = busy_r && half_tick && half_cnt_r[0] && resolving_r;

  always_comb begin
    unique case (kind_r)
      KIND_FIRST: begin
        samp_half  = FIRST_SAMP;
        total_half = FIRST_TOTAL;
      end
      KIND_AUTO: begin
        samp_half  = AUTO_SAMP;
        total_half = AUTO_TOTAL;
      end
      default: begin
        samp_half  = NORM_SAMP;
        total_half = NORM_TOTAL;
      end
    endcase
  end
  // Prescaler, held in reset while disabled and restarted by a trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= '0;
      phase_r   <= 1'b0;
    end else if (!en_r) begin
      pre_cnt_r <= '0;
      phase_r   <= 1'b0;
    end else if (trig_start) begin
      pre_cnt_r <= '0;
      phase_r   <= 1'b1;
    end else if (half_tick) begin
      pre_cnt_r <= '0;
      phase_r   <= !phase_r;
    end else begin
      pre_cnt_r <= pre_cnt_r + PRE_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_d_r   <= 1'b0;
      halted_d_r <= 1'b0;
    end else begin
      trig_d_r   <= trigger_in;
      halted_d_r <= cpu_halted;
    end
  end
  // Conversion timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r     <= 1'b0;
      half_cnt_r <= '0;
      kind_r     <= KIND_NORMAL;
    end else if (!en_r) begin
      busy_r     <= 1'b0;
    end else if (start_any) begin
      busy_r     <= 1'b1;
      half_cnt_r <= '0;
      if (first_pend_r)
        kind_r <= KIND_FIRST;
      else if (trig_start)
        kind_r <= KIND_AUTO;
      else
        kind_r <= KIND_NORMAL;
    end else if (done) begin
      busy_r     <= 1'b0;
    end else if (busy_r && half_tick) begin
      half_cnt_r <= half_cnt_r + 8'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      first_pend_r <= 1'b1;
    else if (!en_r)
      first_pend_r <= 1'b1;
    else if (start_any)
      first_pend_r <= 1'b0;
  end
  // Shadow tracking; frozen from start until the final converter cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      active_r <= '0;
    else if (!busy_r || final_cyc)
      active_r <= shadow_r;
  end
  // Successive approximation, one bit per converter rising edge
  always_comb begin
    sar_nxt = sar_r;
    if (cmp_above)
      sar_nxt = sar_r | (RES_W'(1) << bit_r);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sar_r       <= '0;
      bit_r       <= '0;
      resolving_r <= 1'b0;
      dac_r       <= '0;
      samp_r      <= 1'b0;
    end else begin
      samp_r <= sample;
      if (!en_r) begin
        resolving_r <= 1'b0;
      end else if (sample) begin
        sar_r       <= '0;
        bit_r       <= SAR_TOP;
        resolving_r <= 1'b1;
        dac_r       <= SAR_MSB;
      end else if (sar_step) begin
        sar_r <= sar_nxt;
        if (bit_r == 4'h0) begin
          resolving_r <= 1'b0;
        end else begin
          bit_r <= bit_r - 4'h1;
          dac_r <= sar_nxt | (RES_W'(1) << (bit_r - 4'h1));
        end
      end
    end
  end
  // Result, flag and start request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      result_r <= '0;
    else if (done)
      result_r <= sar_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      flag_r <= 1'b0;
    else if (done)
      flag_r <= 1'b1;
    else if (wr_ctrl && hwdata[CS_FLAG])
      flag_r <= 1'b0;
  end
  // A wake-up never cancels the request; only disable or completion do
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      start_req_r <= 1'b0;
    else if (wr_ctrl && !hwdata[CS_EN])
      start_req_r <= 1'b0;
    else if (done && !restart)
      start_req_r <= 1'b0;
    else if (sleep_start)
      start_req_r <= 1'b1;
    else if (wr_ctrl && hwdata[CS_START] && !busy_r)
      start_req_r <= 1'b1;
  end
  // Control bits, changed only by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r   <= 1'b0;
      auto_r <= 1'b0;
      ie_r   <= 1'b0;
      ps_r   <= '0;
    end else if (wr_ctrl) begin
      en_r   <= hwdata[CS_EN];
      auto_r <= hwdata[CS_AUTO];
      ie_r   <= hwdata[CS_IE];
      ps_r   <= hwdata[CS_PS +: PS_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_r <= '0;
      free_r   <= 1'b0;
    end else if (wr_pend_r && addr_r == OFF_SEL) begin
      shadow_r.ref_sel <= hwdata[SEL_REF +: 2];
      shadow_r.chan    <= hwdata[SEL_CHAN +: 4];
    end else if (wr_pend_r && addr_r == OFF_TRIG) begin
      free_r <= hwdata[TRIG_FREE];
    end
  end
  // Analog switch drive; reserved code keeps the internal reference off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_ext_r <= 1'b0;
      ref_sup_r <= 1'b0;
      ref_bg_r  <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      ref_ext_r <= en_r && (active_r.ref_sel == REF_EXT || active_r.ref_sel == REF_RSVD);
      ref_sup_r <= en_r && (active_r.ref_sel == REF_SUPPLY);
      ref_bg_r  <= en_r && (active_r.ref_sel == REF_BANDGAP);
      irq_r     <= flag_r && ie_r;
    end
  end
  // Bus slave: writes without wait, reads with one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hready_r  <= 1'b1;
      addr_r    <= '0;
      rdata_r   <= '0;
    end else begin
      wr_pend_r <= ap && hwrite;
      rd_pend_r <= ap && !hwrite;
      hready_r  <= !(ap && !hwrite);
      if (ap)
        addr_r <= haddr[7:0];
      if (rd_pend_r) begin
        unique case (addr_r)
          OFF_CTRL: rdata_r <= {24'h0, en_r, start_req_r || busy_r, auto_r, flag_r, ie_r, ps_r};
          OFF_SEL:  rdata_r <= {24'h0, shadow_r.ref_sel, 2'h0, shadow_r.chan};
          OFF_RES:  rdata_r <= {22'h0, result_r};
          OFF_TRIG: rdata_r <= {31'h0, free_r};
          default:  rdata_r <= '0;
        endcase
      end
    end
  end

  assign hrdata       = rdata_r;
  assign hreadyout    = hready_r;
  assign hresp        = 1'b0;
  assign active_sel   = active_r;
  assign ref_ext      = ref_ext_r;
  assign ref_supply   = ref_sup_r;
  assign ref_bandgap  = ref_bg_r;
  assign sample_hold  = samp_r;
  assign dac_code     = dac_r;
  assign converter_on = en_r;
  assign conv_irq     = irq_r;

  logic [15:0]       chk_cyc_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      chk_cyc_r <= '0;
    else
      chk_cyc_r <= start_any ? 16'h0 : chk_cyc_r + 16'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_norm_time;
    done && kind_r == KIND_NORMAL |-> half_cnt_r == 8'd25 && int'(chk_cyc_r) + 1 == 26 * int'(half_len);
  endproperty
  a_norm_time: assert property (p_norm_time) else $error("normal timing wrong");
  property p_auto_samp;
    sample && kind_r == KIND_AUTO |-> half_cnt_r == 8'd3 && int'(chk_cyc_r) + 1 == 4 * int'(half_len);
  endproperty
  a_auto_samp: assert property (p_auto_samp) else $error("auto sample wrong");
  property p_first_len;
    done && kind_r == KIND_FIRST |-> half_cnt_r == 8'd49 && int'(chk_cyc_r) + 1 == 50 * int'(half_len);
  endproperty
  a_first_len: assert property (p_first_len) else $error("first length wrong");
  property p_frozen;
    busy_r && !final_cyc && $past(busy_r) |=> $stable(active_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("selection moved");
  property p_resume;
    final_cyc |=> active_r == $past(shadow_r);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_on_edge;
    $rose(busy_r) |-> $past(rise_tick) || $past(trig_start);
  endproperty
  a_on_edge: assert property (p_on_edge) else $error("start off edge");
  property p_done;
    done && !restart |=> flag_r && !start_req_r && result_r == $past(sar_r);
  endproperty
  a_done: assert property (p_done) else $error("completion wrong");
  property p_sleep;
    sleep_start && !wr_ctrl |=> start_req_r;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep start lost");
  property p_ref;
    en_r && active_r.ref_sel == REF_SUPPLY |=> ref_sup_r && !ref_bg_r && !ref_ext_r;
  endproperty
  a_ref: assert property (p_ref) else $error("reference decode");
  c_first: cover property (done && kind_r == KIND_FIRST);
  c_auto:  cover property (done && kind_r == KIND_AUTO);
  c_free:  cover property (restart);
endmodule
`default_nettype wire

// >>> testbench/acs_analog_model.sv
// Far-side model: channel levels, sample and hold, comparator
`default_nettype none
module acs_analog_model
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Converter side
  input  wire acs_sel_t   active_sel,
  input  wire logic       sample_hold,
  input  wire logic [9:0] dac_code,
  output logic            cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [10:0] held_r;

  // Channel 14 sits above the reference, channel 15 is ground
  function automatic logic [10:0] level(input logic [3:0] ch);
    return (ch == 4'hf) ? 11'h000 : (ch == 4'he) ? 11'h4ff : 11'(ch * 100 + 37);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_r <= 11'h000;
    end else if (sample_hold) begin
      held_r <= level(active_sel.chan);
    end
  end

  // Held level is compared against each trial code
  assign cmp_above = (sample_hold ? level(active_sel.chan) : held_r) >= {1'b0, dac_code};
endmodule
`default_nettype wire

// >>> testbench/acs_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`default_nettype none
module acs_sequencer_test
  import acs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk        = 1'b0;
  logic        hresetn     = 1'b0;
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        trigger_in  = 1'b0;
  logic        cpu_halted  = 1'b0;
  logic [2:0]  sleep_mode  = 3'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, cmp_above, ref_ext, ref_supply, ref_bandgap;
  logic        sample_hold, converter_on, conv_irq;
  logic [9:0]  dac_code;
  acs_sel_t    active_sel;
  logic [31:0] rd;
  logic [3:0]  chans [3]   = '{4'hf, 4'he, 4'h5};
  int          n;
  int          mismatches  = 0;
  int          checks_done = 0;

  always #2.5 hclk = ~hclk;

  acs_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmp_above(cmp_above), .trigger_in(trigger_in),
    .active_sel(active_sel), .ref_ext(ref_ext), .ref_supply(ref_supply), .ref_bandgap(ref_bandgap),
    .sample_hold(sample_hold), .dac_code(dac_code), .converter_on(converter_on),
    .cpu_halted(cpu_halted), .sleep_mode(sleep_mode), .conv_irq(conv_irq));

  acs_analog_model far (.hclk(hclk), .hresetn(hresetn), .active_sel(active_sel),
    .sample_hold(sample_hold), .dac_code(dac_code), .cmp_above(cmp_above));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic bad(input string msg);
    mismatches++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic chk_rng(input int k, input int lo, input int hi, input string what);
    checks_done++;
    if (k < lo || k > hi) bad($sformatf("%s took %0d cycles", what, k));
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? hreadyout : (w == 1) ? sample_hold : conv_irq;
  endfunction

  // Bounded wait for a design output to reach a level
  task automatic wait_lvl(input int w, input logic lvl, inout int cnt);
    int k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (pick(w) !== lvl && k < 300);
    cnt += k;
    if (k >= 300) begin
      bad("wait ran out");
      final_report();
    end
  endtask

  // Interrupt may still be high for a cycle after a flag clear
  task automatic wait_irq();
    wait_lvl(2, 1'b0, n);
    wait_lvl(2, 1'b1, n);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_lvl(0, 1'b1, k);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_lvl(0, 1'b1, k);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // Counts from the launching edge to the sample pulse and to the interrupt
  task automatic meas(input int s, input int t, input string what);
    int k = 0;
    wait_lvl(1, 1'b1, k);
    chk_rng(k, s, s + 6, what);
    wait_lvl(2, 1'b1, k);
    chk_rng(k, t, t + 7, what);
  endtask

  function automatic logic [31:0] exp_code(input logic [3:0] ch);
    return (ch == 4'hf) ? 32'h0 : (ch == 4'he) ? 32'(FULL_SCALE) : 32'(ch * 100 + 37);
  endfunction

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 8'h10, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'(i * 4), 32'h0, "reset or unmapped");
    end
    chk({31'h0, converter_on}, 32'h0, "off at reset");
    chk({31'h0, hresp}, 32'h0, "okay response");
    $display("reset test end");
    bus(1'b1, OFF_CTRL, 32'h89);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, OFF_SEL, 32'(r * 64 + 3));
      repeat (3) @(posedge hclk);
      chk({29'h0, ref_ext, ref_supply, ref_bandgap}, {29'h0, r == 0 || r == 2, r == 1, r == 3}, "ref");
      chk(32'(active_sel), 32'(r * 16 + 3), "idle tracking");
      rd_chk(OFF_SEL, 32'(r * 64 + 3), "select readback");
    end
    $display("reference test end");
    bus(1'b1, OFF_SEL, 32'h43);
    bus(1'b1, OFF_CTRL, 32'hc9);
    meas(27, 50, "first conversion");
    rd_chk(OFF_CTRL, 32'h99, "done status");
    rd_chk(OFF_RES, exp_code(4'h3), "first result");
    foreach (chans[i]) begin
      bus(1'b1, OFF_CTRL, 32'h99);
      bus(1'b1, OFF_SEL, 32'h40 | 32'(chans[i]));
      bus(1'b1, OFF_CTRL, 32'hc9);
      meas(3, 26, "normal conversion");
      rd_chk(OFF_RES, exp_code(chans[i]), "result code");
    end
    $display("conversion test end");
    bus(1'b1, OFF_CTRL, 32'h99);
    bus(1'b1, OFF_SEL, 32'h42);
    bus(1'b1, OFF_CTRL, 32'hc9);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk(rd & 32'h40, 32'h40, "busy bit");
    bus(1'b1, OFF_SEL, 32'h47);
    repeat (3) @(posedge hclk);
    chk(32'(active_sel), 32'h12, "frozen selection");
    wait_irq();
    chk(32'(active_sel), 32'h17, "selection at end");
    rd_chk(OFF_RES, exp_code(4'h2), "locked channel");
    bus(1'b1, OFF_CTRL, 32'h99);
    bus(1'b1, OFF_CTRL, 32'hc9);
    meas(3, 26, "next conversion");
    rd_chk(OFF_RES, exp_code(4'h7), "new channel");
    $display("lock test end");
    bus(1'b1, OFF_CTRL, 32'hb9);
    trigger_in <= 1'b1;
    meas(4, 27, "triggered conversion");
    trigger_in <= 1'b0;
    bus(1'b1, OFF_TRIG, 32'h1);
    bus(1'b1, OFF_SEL, 32'h41);
    bus(1'b1, OFF_CTRL, 32'hf9);
    for (int k = 0; k < 3; k++) begin
      wait_irq();
      if (k == 0) bus(1'b1, OFF_SEL, 32'h44);
      rd_chk(OFF_RES, exp_code(k == 2 ? 4'h4 : 4'h1), "free running");
      bus(1'b1, OFF_CTRL, 32'hb9);
    end
    bus(1'b1, OFF_CTRL, 32'h18);
    bus(1'b1, OFF_TRIG, 32'h0);
    $display("auto test end");
    bus(1'b1, OFF_CTRL, 32'h89);
    sleep_mode <= SLEEP_IDLE;
    cpu_halted <= 1'b1;
    meas(27, 50, "idle sleep start");
    cpu_halted <= 1'b0;
    bus(1'b1, OFF_CTRL, 32'h99);
    sleep_mode <= SLEEP_NR;
    cpu_halted <= 1'b1;
    fork
      meas(3, 26, "woken mid conversion");
      begin
        repeat (10) @(posedge hclk);
        cpu_halted <= 1'b0;
      end
    join
    bus(1'b1, OFF_CTRL, 32'h99);
    sleep_mode <= 3'h2;
    cpu_halted <= 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge hclk);
      if (sample_hold !== 1'b0) n++;
    end
    chk(32'(n), 32'h0, "no start in other sleep");
    chk({31'h0, converter_on}, 32'h1, "still enabled");
    cpu_halted <= 1'b0;
    $display("sleep test end");
    // Switch to the bandgap; the first result after the switch is dropped
    bus(1'b1, OFF_SEL, 32'hc5);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, OFF_CTRL, 32'hd9);
      meas(3, 26, "after reference switch");
      if (j == 1) rd_chk(OFF_RES, exp_code(4'h5), "kept result");
    end
    chk({31'h0, ref_bandgap}, 32'h1, "bandgap selected");
    $display("reference switch test end");
    final_report();
  end
endmodule
`default_nettype wire
